/* File: logic/rcs_reference_clock_select.sv */
// reference clock selection with its serial host register port
// assumes sclk, cs_n, sdi arrive from pins asynchronous to mclk and sclk is
// well below mclk/4; sdo_oe drives the shared data out pin
//
// Overview of operation
// - oscillator lock detector active only when enabled
// - bandwidth bit 0 wide 4x, 1 narrow
// - oscillator select feeds multiplier from oscillator unless direct loop timing is set
// - attenuated loop timing routes recovered clock
// - direct loop timing uses divided recovered clock
// - timing bits 5 to 3 unused
// - two bit map picks transmit, receive inputs
// - map field at bits 7,6, reset zero
// - low frequency select scales references, divide
module rcs_reference_clock_select
  import rcs_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         sclk,
  input  wire logic         cs_n,
  input  wire logic         sdi,
  output logic              sdo,
  output logic              sdo_oe,
  output rcs_clk_sel_t      clk_sel
);

  logic [2:0]       sclk_sync_r;
  logic [1:0]       cs_sync_r;
  logic [1:0]       sdi_sync_r;
  logic             sclk_rise;
  logic             sclk_fall;

  rcs_state_t       state_r;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [15:0]      shift_r;
  logic [7:0]       rd_data;
  logic [7:0]       rd_shift_r;
  logic [7:0]       timing_r;
  logic [7:0]       config_r;
  logic             wr_strobe;
  rcs_clk_sel_t     clk_sel_nxt;

  // pin synchronisers; edge detect reads second stage onward only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_r <= 3'h0;
      cs_sync_r   <= 2'h3;
      sdi_sync_r  <= 2'h0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], sclk};
      cs_sync_r   <= {cs_sync_r[0], cs_n};
      sdi_sync_r  <= {sdi_sync_r[0], sdi};
    end
  end

  assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
  assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];

  // frame: r/w bit, 7 address bits, 8 data bits, msb first
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= RCS_ST_IDLE;
      bit_cnt_r <= '0;
      shift_r   <= 16'h0000;
    end else begin
      case (state_r)
        RCS_ST_IDLE: begin
          bit_cnt_r <= '0;
          if (!cs_sync_r[1]) begin
            state_r <= RCS_ST_SHIFT;
          end
        end
        RCS_ST_SHIFT: begin
          if (cs_sync_r[1]) begin
            state_r <= RCS_ST_IDLE;
          end else if (sclk_rise) begin
            shift_r   <= {shift_r[14:0], sdi_sync_r[1]};
            bit_cnt_r <= bit_cnt_r + 1'b1;
            if (bit_cnt_r == CNT_W'(FRAME_BITS - 1)) begin
              state_r <= RCS_ST_DONE;
            end
          end
        end
        RCS_ST_DONE: begin
          if (cs_sync_r[1]) begin
            state_r <= RCS_ST_IDLE;
          end
        end
        default: state_r <= RCS_ST_IDLE;
      endcase
    end
  end

  // write lands on the sixteenth rising sclk of a write frame
  assign wr_strobe = (state_r == RCS_ST_SHIFT) && !cs_sync_r[1] && sclk_rise
                     && (bit_cnt_r == CNT_W'(FRAME_BITS - 1)) && !shift_r[14];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timing_r <= TC_RESET;
      config_r <= CC_RESET;
    end else if (wr_strobe) begin
      if (shift_r[13:7] == ADDR_TIMING) begin
        timing_r <= {shift_r[6:0], sdi_sync_r[1]} & TC_RW_MASK;
      end
      if (shift_r[13:7] == ADDR_CONFIG) begin
        config_r <= {shift_r[6:0], sdi_sync_r[1]} & CC_RW_MASK;
      end
    end
  end

  // readback; unmapped addresses read zero
  always_comb begin
    case (shift_r[6:0])
      ADDR_TIMING: rd_data = timing_r;
      ADDR_CONFIG: rd_data = config_r;
      default:     rd_data = 8'h00;
    endcase
  end

  // read data driven on falling sclk after the address byte
  // the word is latched at the first fall: the address in shift_r moves on
  // as further bits arrive, so a live lookup would read the wrong register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sdo        <= 1'b0;
      sdo_oe     <= 1'b0;
      rd_shift_r <= 8'h00;
    end else if (cs_sync_r[1] || state_r == RCS_ST_IDLE) begin
      sdo        <= 1'b0;
      sdo_oe     <= 1'b0;
    end else if (sclk_fall && state_r == RCS_ST_SHIFT &&
                 shift_r[7] == 1'b1 && bit_cnt_r == CNT_W'(8)) begin
      sdo        <= rd_data[7];
      sdo_oe     <= 1'b1;
      rd_shift_r <= {rd_data[6:0], 1'b0};
    end else if (sclk_fall && state_r == RCS_ST_SHIFT && sdo_oe) begin
      sdo        <= rd_shift_r[7];
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
    end else if (state_r == RCS_ST_DONE && sclk_fall) begin
      // pin released: data line returns to its idle level as well
      sdo        <= 1'b0;
      sdo_oe     <= 1'b0;
    end
  end

  // source selection
  always_comb begin
    clk_sel_nxt = '0;
    clk_sel_nxt.osc_lock_detect_enable  = timing_r[TC_LOCK_EN];
    clk_sel_nxt.narrow_bandwidth        = timing_r[TC_BW_SEL];
    clk_sel_nxt.dejitter_from_recovered = timing_r[TC_LOOP_ATT];
    clk_sel_nxt.low_frequency_select    = config_r[CC_LOW_FREQ];
    // low references are half rate, so the divide by 32 is dropped
    clk_sel_nxt.recovered_div_32        = ~config_r[CC_LOW_FREQ];
    clk_sel_nxt.cdr_use_second          = config_r[CC_MAP_LO];
    if (timing_r[TC_LOOP_ATT]) begin
      clk_sel_nxt.cmu_src = RCS_SRC_OSC;
    end else if (timing_r[TC_LOOP_DIR]) begin
      clk_sel_nxt.cmu_src = RCS_SRC_RECOV;
    end else if (timing_r[TC_OSC_SEL]) begin
      clk_sel_nxt.cmu_src = RCS_SRC_OSC;
    end else if (config_r[CC_MAP_HI]) begin
      clk_sel_nxt.cmu_src = RCS_SRC_REF2;
    end else begin
      clk_sel_nxt.cmu_src = RCS_SRC_REF1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel <= '{cmu_src: RCS_SRC_REF1, low_frequency_select: 1'b1,
                   recovered_div_32: 1'b0, default: 1'b0};
    end else begin
      clk_sel <= clk_sel_nxt;
    end
  end

endmodule

/* File: logic/rcs_pkg.sv */
// package for the reference clock select block: register map, fields, types
// assumes one 25 MHz clock domain; serial port pins are asynchronous
package rcs_pkg;

  localparam int          MCLK_HZ        = 25_000_000;
  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam int          FRAME_BITS     = 16;
  localparam int          CNT_W          = 5;

  localparam logic [6:0]  ADDR_TIMING    = 7'h06;
  localparam logic [6:0]  ADDR_CONFIG    = 7'h07;

  // timing control fields
  localparam int          TC_LOCK_EN     = 7;
  localparam int          TC_BW_SEL      = 6;
  localparam int          TC_OSC_SEL     = 2;
  localparam int          TC_LOOP_ATT    = 1;
  localparam int          TC_LOOP_DIR    = 0;
  localparam logic [7:0]  TC_RW_MASK     = 8'h0C7;
  localparam logic [7:0]  TC_RESET       = 8'h00;

  // configuration control fields
  localparam int          CC_MAP_HI      = 7;
  localparam int          CC_MAP_LO      = 6;
  localparam int          CC_LOW_FREQ    = 5;
  localparam logic [7:0]  CC_RW_MASK     = 8'h0E0;
  localparam logic [7:0]  CC_RESET       = 8'h20;

  typedef enum logic [1:0] {
    RCS_SRC_REF1  = 2'b00,
    RCS_SRC_REF2  = 2'b01,
    RCS_SRC_OSC   = 2'b10,
    RCS_SRC_RECOV = 2'b11
  } rcs_src_t;

  typedef enum logic [1:0] {
    RCS_ST_IDLE  = 2'b00,
    RCS_ST_SHIFT = 2'b01,
    RCS_ST_DONE  = 2'b10
  } rcs_state_t;

  typedef struct packed {
    rcs_src_t   cmu_src;
    logic       cdr_use_second;
    logic       narrow_bandwidth;
    logic       osc_lock_detect_enable;
    logic       dejitter_from_recovered;
    logic       recovered_div_32;
    logic       low_frequency_select;
  } rcs_clk_sel_t;

endpackage

/* File: testbench/rcs_props.sv */
// port checker for the reference clock select block
// bound onto the block by the bench top; single mclk domain
module rcs_props
  import rcs_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire logic         sclk,
  input wire logic         cs_n,
  input wire logic         sdi,
  input wire logic         sdo,
  input wire logic         sdo_oe,
  input wire rcs_clk_sel_t clk_sel
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  att_wins_a: assert property (clk_sel.dejitter_from_recovered
    |-> clk_sel.cmu_src == RCS_SRC_OSC) else $error("att src");
  div_ratio_a: assert property (clk_sel.recovered_div_32
    == !clk_sel.low_frequency_select) else $error("div ratio");
  sdo_idle_a: assert property (!sdo_oe |-> !sdo)
    else $error("sdo idle");
  oe_off_a: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("oe off");
  sel_hold_a: assert property (cs_n [*8] |=> $stable(clk_sel))
    else $error("sel moved");
  reset_val_a: assert property ($rose(rst_n) |->
    clk_sel.cmu_src == RCS_SRC_REF1 && !clk_sel.cdr_use_second &&
    !clk_sel.narrow_bandwidth && !clk_sel.osc_lock_detect_enable)
    else $error("reset val");
  oe_frame_a: assert property ($rose(sdo_oe) |-> !cs_n)
    else $error("oe frame");
  recov_dir_a: assert property (clk_sel.cmu_src == RCS_SRC_RECOV
    |-> !clk_sel.dejitter_from_recovered) else $error("recov");
endmodule

/* File: testbench/test_rcs_reference_clock_select.sv */
// bench for the reference clock select block
// drives the serial host port itself; expects the rcs_pkg map
module test_rcs_reference_clock_select;
  import rcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe;
  rcs_clk_sel_t clk_sel;
  logic [7:0]   q;
  logic         oe_seen;
  int           fail_count = 0;
  int           num_checks = 0;
  rcs_reference_clock_select u_rcs_reference_clock_select (.mclk(mclk),
    .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .clk_sel(clk_sel));
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %0t seen %h want %h", $time, s, e);
    end
  endtask
  // one 16 bit frame, read data sampled on sclk rise
  task automatic xf(logic r, logic [6:0] a, logic [7:0] d);
    logic [15:0] f;
    f = {r, a, d};
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi <= f[i];
      wt(6);
      sclk <= 1'b1;
      if (i < 8) q[i] = sdo;
      if (i == 0) oe_seen = sdo_oe;
      wt(6);
      sclk <= 1'b0;
    end
    wt(6);
    cs_n <= 1'b1;
    wt(8);
  endtask
  task automatic t_reset;
    xf(1, ADDR_TIMING, 0);
    chk(q, 8'h00);
    xf(1, ADDR_CONFIG, 0);
    chk(q, CC_RESET);
    chk(oe_seen, 1'b1);
    chk(clk_sel.cmu_src, RCS_SRC_REF1);
    $display("t_reset done");
  endtask
  task automatic t_map;
    for (int m = 0; m < 4; m++) begin
      xf(0, ADDR_CONFIG, {m[1:0], 6'h3F});
      chk(clk_sel.cmu_src, m[1] ? RCS_SRC_REF2 : RCS_SRC_REF1);
      chk(clk_sel.cdr_use_second, m[0]);
      xf(1, ADDR_CONFIG, 0);
      chk(q, {m[1:0], 6'h20});
    end
    xf(0, ADDR_CONFIG, 8'h00);
    chk(clk_sel.low_frequency_select, 0);
    chk(clk_sel.recovered_div_32, 1);
    xf(0, 7'h10, 8'hFF);
    chk(oe_seen, 1'b0);
    xf(1, 7'h10, 0);
    chk(q, 8'h00);
    $display("t_map done");
  endtask
  task automatic t_timing;
    xf(0, ADDR_TIMING, 8'hFF);
    xf(1, ADDR_TIMING, 0);
    chk(q, 8'hC7);
    chk(clk_sel.osc_lock_detect_enable, 1);
    chk(clk_sel.narrow_bandwidth, 1);
    chk(clk_sel.dejitter_from_recovered, 1);
    chk(clk_sel.cmu_src, RCS_SRC_OSC);
    xf(0, ADDR_TIMING, 8'h01);
    chk(clk_sel.cmu_src, RCS_SRC_RECOV);
    chk(clk_sel.dejitter_from_recovered, 0);
    chk(clk_sel.osc_lock_detect_enable, 0);
    chk(clk_sel.narrow_bandwidth, 0);
    xf(0, ADDR_TIMING, 8'h04);
    chk(clk_sel.cmu_src, RCS_SRC_OSC);
    $display("t_timing done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #1_000_000;
    fail_count++;
    give_verdict();
  end
  initial begin
    rst_n = 0;
    sclk = 0;
    cs_n = 1;
    sdi = 0;
    q = 0;
    oe_seen = 0;
    wt(5);
    rst_n <= 1'b1;
    wt(4);
    t_reset();
    t_map();
    t_timing();
    give_verdict();
  end
endmodule
bind rcs_reference_clock_select rcs_props u_rcs_props (.mclk(mclk),
  .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
  .sdo_oe(sdo_oe), .clk_sel(clk_sel));
